// ---- aomc_pkg.sv ----
// constants and types for the analog output multiplexer control block
// Summary of operation
// [R1] With an output's unity gain select at 1 the output gain is 1.0 whatever its two-bit gain select holds.
// [R2] With unity gain select at 0 the gain select picks 1.33 on 00, 2.0 on 01, 3.0 on 10 and 5.33 on 11.
// [R3] Only gains 3.0 and 5.33 strip the nominal input bias before amplification and restore it after.
// [R4] The first output, when enabled, routes feedback 1 on 000, feedback 3 on 001, the core supply on 101.
// [R5] The second output, when enabled with flag source and owner both 0, routes feedback 2 on 000, feedback 4 on 001, the core supply on 101.
// [R6] The third output, when enabled, routes feedback 5 on 000, feedback 6 on 001, the core supply on 101.
// [R7] An output whose drive enable is 0 is high impedance whatever its source select holds, except the second output when it is a flag output (R11).
// [R8] Software must not select a source that is already routed through another output or internal path.
// [R9] The second pin can serve as flag-bus line 14, input or output, through the same output stage.
// [R10] Flag source 0 with owner 0 makes the second buffer follow its drive enable; direction is ignored.
// [R11] Flag source 1 with owner 1 makes the second pin an input (buffer off) on direction 1, an output on 0.
// [R12] Software sets the second pin's digital level by its gain select: 00 for 3.3 V, 01 for 5.0 V.
package aomc_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_OUT_CFG = 8'h00;
   localparam logic [7:0] OFS_FLAG_CFG = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;

   // analog_output_config field positions
   localparam int POS_SEL1 = 0;
   localparam int POS_EN1 = 3;
   localparam int POS_SEL2 = 4;
   localparam int POS_EN2 = 7;
   localparam int POS_SEL3 = 8;
   localparam int POS_EN3 = 11;
   localparam int POS_GAIN1 = 12;
   localparam int POS_UNITY1 = 14;
   localparam int POS_GAIN2 = 16;
   localparam int POS_UNITY2 = 18;
   localparam int POS_GAIN3 = 20;
   localparam int POS_UNITY3 = 22;

   // flag configuration field positions
   localparam int POS_FLAG_SRC = 0;
   localparam int POS_FLAG_DIR = 1;
   localparam int POS_PIN_OWNER = 2;

   // writable bits and reset values
   localparam logic [31:0] OUT_CFG_MASK = 32'h0077_7FFF;
   localparam logic [31:0] FLAG_CFG_MASK = 32'h0000_0007;
   localparam logic [31:0] OUT_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] FLAG_CFG_RESET = 32'h0000_0000;

   // source select codes
   localparam logic [2:0] SRC_FB_A = 3'h0;
   localparam logic [2:0] SRC_FB_B = 3'h1;
   localparam logic [2:0] SRC_SUPPLY = 3'h5;

   // one-hot route to the analog mux
   localparam logic [2:0] ROUTE_NONE = 3'h0;
   localparam logic [2:0] ROUTE_FB_A = 3'h1;
   localparam logic [2:0] ROUTE_FB_B = 3'h2;
   localparam logic [2:0] ROUTE_SUPPLY = 3'h4;

   // gain steps of the output amplifier
   typedef enum logic [2:0] {
      GAIN_1P00 = 3'h0,
      GAIN_1P33 = 3'h1,
      GAIN_2P00 = 3'h2,
      GAIN_3P00 = 3'h3,
      GAIN_5P33 = 3'h4
   } aomc_gain_t;

   // decoded source of an output
   typedef struct packed {
      logic [2:0] route;
      logic reserved;
   } aomc_route_t;

endpackage

// ---- aomc_core.sv ----
// analog output multiplexer, gain and second-pin flag control with apb registers
module aomc_core #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // first output control
   output logic [2:0] first_route,
   output logic first_drive,
   output aomc_pkg::aomc_gain_t first_gain,
   output logic first_bias_strip,
   // second output control
   output logic [2:0] second_route,
   output logic second_drive,
   output aomc_pkg::aomc_gain_t second_gain,
   output logic second_bias_strip,
   output logic second_digital_mode,
   // third output control
   output logic [2:0] third_route,
   output logic third_drive,
   output aomc_pkg::aomc_gain_t third_gain,
   output logic third_bias_strip,
   // second pin as flag line 14
   input wire logic pin_second_in,
   output logic pin_second_out,
   output logic pin_second_oe_n,
   input wire logic flag14_drive_in,
   output logic flag14_sense_out
);
   import aomc_pkg::*;

   // refuse address widths that cannot reach the status register
   if (ADDR_W < 4) begin : g_addr_chk
      $error("ADDR_W must be at least 4");
   end

   // source select decode shared by the three outputs
   function automatic aomc_route_t decode_route(input logic [2:0] sel, input logic en);
      aomc_route_t r;
      r.route = ROUTE_NONE;
      r.reserved = 1'b0;
      if (en) begin
         case (sel)
            SRC_FB_A: r.route = ROUTE_FB_A;
            SRC_FB_B: r.route = ROUTE_FB_B;
            SRC_SUPPLY: r.route = ROUTE_SUPPLY;
            default: r.reserved = 1'b1;
         endcase
      end
      return r;
   endfunction

   // gain decode shared by the three outputs
   function automatic aomc_gain_t decode_gain(input logic unity, input logic [1:0] code);
      aomc_gain_t g;
      g = GAIN_1P00;
      if (!unity) begin
         case (code)
            2'h0: g = GAIN_1P33;
            2'h1: g = GAIN_2P00;
            2'h2: g = GAIN_3P00;
            2'h3: g = GAIN_5P33;
            default: g = GAIN_1P33;
         endcase
      end
      return g;
   endfunction

   // bias handling follows the gain step
   function automatic logic strips_bias(input aomc_gain_t g);
      return (g == GAIN_3P00) || (g == GAIN_5P33);
   endfunction

   // byte-lane merge for writes
   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
      return (old & ~m) | (wd & m);
   endfunction

   // registers
   logic [31:0] out_cfg_reg;
   logic [31:0] out_cfg_next;
   logic [31:0] flag_cfg_reg;
   logic [31:0] flag_cfg_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [2:0] first_route_reg;
   logic [2:0] second_route_reg;
   logic [2:0] third_route_reg;
   logic first_drive_reg;
   logic second_drive_reg;
   logic third_drive_reg;
   aomc_gain_t first_gain_reg;
   aomc_gain_t second_gain_reg;
   aomc_gain_t third_gain_reg;
   logic first_bias_reg;
   logic second_bias_reg;
   logic third_bias_reg;
   logic second_digital_reg;
   logic pin_out_reg;
   logic pin_oe_n_reg;
   logic flag_sense_reg;

   // bus decode
   wire logic [7:0] addr_byte;
   wire logic hit_out_cfg;
   wire logic hit_flag_cfg;
   wire logic hit_status;
   wire logic hit_any;
   wire logic access_phase;
   wire logic access_done;
   wire logic write_done;

   assign addr_byte = 8'(paddr);
   assign hit_out_cfg = (addr_byte == OFS_OUT_CFG);
   assign hit_flag_cfg = (addr_byte == OFS_FLAG_CFG);
   assign hit_status = (addr_byte == OFS_STATUS);
   assign hit_any = hit_out_cfg | hit_flag_cfg | hit_status;
   assign access_phase = psel & penable;
   assign access_done = access_phase & pready_reg; // transfer ends at this edge
   assign write_done = access_done & pwrite & hit_any;

   // configuration fields
   wire logic [2:0] sel1;
   wire logic [2:0] sel2;
   wire logic [2:0] sel3;
   wire logic en1;
   wire logic en2;
   wire logic en3;
   wire logic [1:0] gsel1;
   wire logic [1:0] gsel2;
   wire logic [1:0] gsel3;
   wire logic unity1;
   wire logic unity2;
   wire logic unity3;
   wire logic flag_src;
   wire logic flag_dir;
   wire logic pin_owner;

   assign sel1 = out_cfg_reg[POS_SEL1 +: 3];
   assign sel2 = out_cfg_reg[POS_SEL2 +: 3];
   assign sel3 = out_cfg_reg[POS_SEL3 +: 3];
   assign en1 = out_cfg_reg[POS_EN1];
   assign en2 = out_cfg_reg[POS_EN2];
   assign en3 = out_cfg_reg[POS_EN3];
   assign gsel1 = out_cfg_reg[POS_GAIN1 +: 2];
   assign gsel2 = out_cfg_reg[POS_GAIN2 +: 2];
   assign gsel3 = out_cfg_reg[POS_GAIN3 +: 2];
   assign unity1 = out_cfg_reg[POS_UNITY1];
   assign unity2 = out_cfg_reg[POS_UNITY2];
   assign unity3 = out_cfg_reg[POS_UNITY3];
   assign flag_src = flag_cfg_reg[POS_FLAG_SRC];
   assign flag_dir = flag_cfg_reg[POS_FLAG_DIR];
   assign pin_owner = flag_cfg_reg[POS_PIN_OWNER];

   // second pin mode: analog, digital input, digital output or parked
   wire logic mode_analog;
   wire logic mode_digital;
   wire logic mode_dig_in;
   wire logic mode_dig_out;

   assign mode_analog = ~flag_src & ~pin_owner; // R10
   assign mode_digital = flag_src & pin_owner; // R9
   assign mode_dig_in = mode_digital & flag_dir; // R11
   assign mode_dig_out = mode_digital & ~flag_dir; // R11

   // source routing per output; a disabled output routes nothing
   aomc_route_t route1;
   aomc_route_t route2;
   aomc_route_t route3;

   assign route1 = decode_route(sel1, en1); // R4 R7
   assign route2 = decode_route(sel2, en2 & mode_analog); // R5 R7
   assign route3 = decode_route(sel3, en3); // R6 R7

   // gain per output
   aomc_gain_t gain1;
   aomc_gain_t gain2;
   aomc_gain_t gain3;

   assign gain1 = decode_gain(unity1, gsel1); // R1 R2
   assign gain2 = decode_gain(unity2, gsel2); // R1 R2 R12
   assign gain3 = decode_gain(unity3, gsel3); // R1 R2

   // buffer states
   wire logic drive1;
   wire logic drive2;
   wire logic drive3;

   assign drive1 = en1; // R7
   assign drive2 = (mode_analog & en2) | mode_dig_out; // R10 R11
   assign drive3 = en3; // R7

   // status word
   wire logic [31:0] status_word;

   assign status_word = {23'h0, route3.reserved, route2.reserved, route1.reserved, pin_second_in,
                         mode_dig_out, mode_dig_in, drive3, drive2, drive1};

   // read mux
   wire logic [31:0] read_word;

   assign read_word = hit_out_cfg ? out_cfg_reg :
                      hit_flag_cfg ? flag_cfg_reg :
                      hit_status ? status_word : 32'h0000_0000;

   // one wait state, then answer with data and error flag
   assign pready_next = access_phase & ~pready_reg;
   assign prdata_next = (pready_next & ~pwrite) ? read_word : 32'h0000_0000;
   assign pslverr_next = pready_next & ~hit_any;

   // register writes; status is read only
   assign out_cfg_next = (write_done & hit_out_cfg) ?
                         merge_strb(out_cfg_reg, pwdata, pstrb, OUT_CFG_MASK) : out_cfg_reg;
   assign flag_cfg_next = (write_done & hit_flag_cfg) ?
                          merge_strb(flag_cfg_reg, pwdata, pstrb, FLAG_CFG_MASK) : flag_cfg_reg;

   // bus side flip-flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         out_cfg_reg <= OUT_CFG_RESET;
         flag_cfg_reg <= FLAG_CFG_RESET;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         out_cfg_reg <= out_cfg_next;
         flag_cfg_reg <= flag_cfg_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // analog mux control flip-flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         first_route_reg <= ROUTE_NONE;
         second_route_reg <= ROUTE_NONE;
         third_route_reg <= ROUTE_NONE;
         first_drive_reg <= 1'b0;
         second_drive_reg <= 1'b0;
         third_drive_reg <= 1'b0;
      end else begin
         first_route_reg <= route1.route; // R4
         second_route_reg <= route2.route; // R5
         third_route_reg <= route3.route; // R6
         first_drive_reg <= drive1; // R7
         second_drive_reg <= drive2; // R10 R11
         third_drive_reg <= drive3; // R7
      end
   end

   // gain and bias flip-flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         first_gain_reg <= GAIN_1P33;
         second_gain_reg <= GAIN_1P33;
         third_gain_reg <= GAIN_1P33;
         first_bias_reg <= 1'b0;
         second_bias_reg <= 1'b0;
         third_bias_reg <= 1'b0;
      end else begin
         first_gain_reg <= gain1;
         second_gain_reg <= gain2;
         third_gain_reg <= gain3;
         first_bias_reg <= strips_bias(gain1); // R3
         second_bias_reg <= strips_bias(gain2); // R3
         third_bias_reg <= strips_bias(gain3); // R3
      end
   end

   // second pin digital path through the analog output stage
   always_ff @(posedge mclk) begin
      if (reset) begin
         second_digital_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_n_reg <= 1'b1;
         flag_sense_reg <= 1'b0;
      end else begin
         second_digital_reg <= mode_dig_out; // R9
         pin_out_reg <= mode_dig_out & flag14_drive_in; // R9
         pin_oe_n_reg <= ~mode_dig_out; // R11
         flag_sense_reg <= mode_dig_in & pin_second_in; // R9 R11
      end
   end

   // outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign first_route = first_route_reg;
   assign first_drive = first_drive_reg;
   assign first_gain = first_gain_reg;
   assign first_bias_strip = first_bias_reg;
   assign second_route = second_route_reg;
   assign second_drive = second_drive_reg;
   assign second_gain = second_gain_reg;
   assign second_bias_strip = second_bias_reg;
   assign second_digital_mode = second_digital_reg;
   assign third_route = third_route_reg;
   assign third_drive = third_drive_reg;
   assign third_gain = third_gain_reg;
   assign third_bias_strip = third_bias_reg;
   assign pin_second_out = pin_out_reg;
   assign pin_second_oe_n = pin_oe_n_reg;
   assign flag14_sense_out = flag_sense_reg;

endmodule

// ---- aomc_properties.sv ----
// port-level checks for the analog output mux control block
module aomc_properties (
   // clock, reset and apb
   input wire logic mclk,
   input wire logic reset,
   input wire logic pwrite,
   input wire logic pready,
   // output controls
   input wire logic [2:0] first_route,
   input wire logic first_drive,
   input wire aomc_pkg::aomc_gain_t first_gain,
   input wire logic first_bias_strip,
   input wire logic [2:0] second_route,
   input wire logic second_drive,
   input wire logic second_digital_mode,
   // second pin
   input wire logic pin_second_out,
   input wire logic pin_second_oe_n,
   input wire logic flag14_drive_in
);
   import aomc_pkg::*;

   // all checks share one clock and reset
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   property p_bias_gain; first_bias_strip == (first_gain == GAIN_3P00 || first_gain == GAIN_5P33); endproperty
   a_bias_gain: assert property (p_bias_gain) else $error("bias strip wrong for gain");
   property p_route_code; $onehot0(first_route); endproperty
   a_route_code: assert property (p_route_code) else $error("first route not one-hot");
   property p_route_drive; first_route != ROUTE_NONE |-> first_drive; endproperty
   a_route_drive: assert property (p_route_drive) else $error("first route while off");
   property p_second_route; second_route != ROUTE_NONE |-> second_drive && !second_digital_mode; endproperty
   a_second_route: assert property (p_second_route) else $error("second route outside analog");
   property p_digital_oe; !pin_second_oe_n |-> second_digital_mode && second_drive; endproperty
   a_digital_oe: assert property (p_digital_oe) else $error("pin driven outside output mode");
   property p_pin_follow;
      second_digital_mode && $past(second_digital_mode) |-> pin_second_out == $past(flag14_drive_in);
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("pin level not following flag");
   property p_pin_idle; !second_digital_mode |-> !pin_second_out && pin_second_oe_n; endproperty
   a_pin_idle: assert property (p_pin_idle) else $error("pin active outside output mode");
   property p_cfg_hold; $changed(first_gain) |-> $past(pready && pwrite, 2); endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("gain moved without a write");
endmodule

// ---- aomc_partner.sv ----
// flag bus and pin model on the far side of the second output
module aomc_partner (
   // pin side of the design
   input wire logic pin_oe_n,
   input wire logic pin_out,
   // flag bus driver
   input wire logic bus_drive,
   input wire logic bus_val,
   output logic pin_level
);
   // wire level: contention is unknown, released pin sits at the weak pull-down
   assign pin_level = (!pin_oe_n && bus_drive) ? 1'bx : !pin_oe_n ? pin_out : bus_drive ? bus_val : 1'b0;
endmodule

// ---- analog_output_mux_control_tb.sv ----
// self-checking bench for the analog output mux control block
module analog_output_mux_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import aomc_pkg::*;

   typedef struct packed {
      logic [31:0] cfg;
      logic [2:0] flag;
      logic [8:0] rt;
      logic [2:0] dr;
      logic [8:0] gn;
      logic [2:0] bs;
      logic [2:0] mos;
   } aomc_row_t;

   logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic fdrv = 1'b0, bus_drive = 1'b0, bus_val = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, err, pin_level, d1, d2, d3, b1, b2, b3, dm, pout, oen, sense;
   logic [2:0] r1, r2, r3;
   aomc_gain_t g1, g2, g3;
   int n_errors = 0, checks = 0, cyc = 0;
   // config, flag, routes, drives, gains, bias, {digital out, oe_n, sense}; no source on two outputs at once
   aomc_row_t rows [10] = '{
      {32'h0000_0888, 3'h0, 9'h049, 3'h7, 9'h049, 3'h0, 3'b010},
      {32'h0011_1999, 3'h0, 9'h092, 3'h7, 9'h092, 3'h0, 3'b010},
      {32'h0022_298D, 3'h0, 9'h08C, 3'h7, 9'h0DB, 3'h7, 3'b010},
      {32'h0033_3FCA, 3'h0, 9'h000, 3'h7, 9'h124, 3'h7, 3'b010},
      {32'h0077_7555, 3'h0, 9'h000, 3'h0, 9'h000, 3'h0, 3'b010},
      {32'h0000_0888, 3'h5, 9'h041, 3'h7, 9'h049, 3'h0, 3'b100},
      {32'h0000_0888, 3'h7, 9'h041, 3'h5, 9'h049, 3'h0, 3'b011},
      {32'h0000_0888, 3'h1, 9'h041, 3'h5, 9'h049, 3'h0, 3'b010},
      {32'h0000_0888, 3'h2, 9'h049, 3'h7, 9'h049, 3'h0, 3'b010},
      {32'h0000_0000, 3'h0, 9'h000, 3'h0, 9'h049, 3'h0, 3'b010}};

   // clock and cycle ceiling
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         end_of_test();
      end
   end

   aomc_core uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_route(r1), .first_drive(d1), .first_gain(g1), .first_bias_strip(b1),
      .second_route(r2), .second_drive(d2), .second_gain(g2), .second_bias_strip(b2),
      .second_digital_mode(dm), .third_route(r3), .third_drive(d3), .third_gain(g3), .third_bias_strip(b3),
      .pin_second_in(pin_level), .pin_second_out(pout), .pin_second_oe_n(oen),
      .flag14_drive_in(fdrv), .flag14_sense_out(sense));
   aomc_partner far (.pin_oe_n(oen), .pin_out(pout), .bus_drive(bus_drive), .bus_val(bus_val),
      .pin_level(pin_level));

   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a transfer that never completes counts as a mismatch
      if (pready !== 1'b1) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, pready, 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // reset, table rows, then hand-written cases
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      chk({6'h0, r3, r2, r1, d3, d2, d1, g3, g2, g1, b3, b2, b1, dm, oen}, {6'h0, 21'h49, 5'h01});
      apb(1'b0, OFS_FLAG_CFG, 32'h0, 4'hF);
      chk(rd, FLAG_CFG_RESET);
      $display("reset test done");
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, OFS_OUT_CFG, rows[i].cfg, 4'hF);
         apb(1'b1, OFS_FLAG_CFG, {29'h0, rows[i].flag}, 4'hF);
         apb(1'b0, OFS_OUT_CFG, 32'h0, 4'hF);
         chk(rd, rows[i].cfg);
         repeat (3) @(posedge mclk);
         chk({6'h0, r3, r2, r1, d3, d2, d1, g3, g2, g1, b3, b2, b1, dm, oen},
            {6'h0, rows[i].rt, rows[i].dr, rows[i].gn, rows[i].bs, rows[i].mos[2:1]});
         fdrv <= 1'b1;
         bus_val <= 1'b1;
         bus_drive <= rows[i].mos[1];
         repeat (3) @(posedge mclk);
         chk({30'h0, pout, sense}, {30'h0, rows[i].mos[2], rows[i].mos[0]});
         fdrv <= 1'b0;
         bus_val <= 1'b0;
         bus_drive <= 1'b0;
         $display("row %0d done", i);
      end
      // byte lanes, unmapped place, read-only status
      apb(1'b1, OFS_OUT_CFG, 32'hFFFF_FFFF, 4'h1);
      apb(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h0C, 32'h0, 4'hF);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
      chk({31'h0, err}, 32'h0);
      apb(1'b0, OFS_OUT_CFG, 32'h0, 4'hF);
      chk(rd, 32'h0000_00FF);
      apb(1'b0, OFS_STATUS, 32'h0, 4'hF);
      chk(rd, 32'h0000_00C3);
      $display("register test done");
      // second reset in mid-run
      apb(1'b1, OFS_FLAG_CFG, 32'h0000_0005, 4'hF);
      reset <= 1'b1;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      apb(1'b0, OFS_FLAG_CFG, 32'h0, 4'hF);
      chk(rd, FLAG_CFG_RESET);
      chk({30'h0, d2, oen}, 32'h1);
      $display("second reset test done");
      end_of_test();
   end
endmodule

bind aomc_core aomc_properties props (.mclk(mclk), .reset(reset), .pwrite(pwrite), .pready(pready),
   .first_route(first_route), .first_drive(first_drive), .first_gain(first_gain),
   .first_bias_strip(first_bias_strip), .second_route(second_route), .second_drive(second_drive),
   .second_digital_mode(second_digital_mode), .pin_second_out(pin_second_out),
   .pin_second_oe_n(pin_second_oe_n), .flag14_drive_in(flag14_drive_in));
